//--- rtl/host_port_pkg.sv
// Purpose: shared constants and types for the byte-lane host port and its host end
// Assumes: one 50 MHz clock, synchronous active-low reset
// Notes: configuration byte layout, command field layout, acknowledge styles
package host_port_pkg;
	localparam int BUS_W           = 16;
	localparam int BYTE_W          = 8;
	localparam int NUM_SRC         = 4;
	// configuration byte fields
	localparam int CFG_SWAP_EN_BIT  = 7;
	localparam int CFG_SWAP_SEL_BIT = 6;
	localparam int CFG_ACK_HI_BIT   = 2;
	localparam int CFG_ACK_LO_BIT   = 1;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// command/pointer byte fields
	localparam int CMD_PTR_LO   = 0;
	localparam int CMD_PTR_HI   = 2;
	localparam int CMD_CODE_LO  = 3;
	localparam int CMD_CODE_HI  = 5;
	localparam int CMD_CRC_LO   = 6;
	localparam int CMD_CRC_HI   = 7;
	localparam logic [3:0] PTR_RESET = 4'h0;
	// handshake timing counts
	localparam logic [3:0] HOLD_CYCLES   = 4'h6;
	localparam logic [3:0] RELEASE_GAP   = 4'h4;
	localparam logic [1:0] DMA_LAST_STEP = 2'h3;
	// acknowledge style encodings (cfg bits 2:1)
	localparam logic [1:0] ACK_STATUS = 2'h0;
	localparam logic [1:0] ACK_SINGLE = 2'h1;
	localparam logic [1:0] ACK_RSVD   = 2'h2;
	localparam logic [1:0] ACK_DOUBLE = 2'h3;
	typedef enum logic [2:0] {
		CMD_NULL      = 3'h0,
		CMD_POINT_HI  = 3'h1,
		CMD_RST_STAT  = 3'h2,
		CMD_ABORT     = 3'h3,
		CMD_INT_NEXT  = 3'h4,
		CMD_RST_TXINT = 3'h5,
		CMD_ERR_RST   = 3'h6,
		CMD_RST_IUS   = 3'h7
	} command_t;
	typedef enum logic [1:0] {
		CRC_NULL  = 2'h0,
		CRC_RX    = 2'h1,
		CRC_TX    = 2'h2,
		CRC_EOM   = 2'h3
	} crc_cmd_t;
	// acknowledge tracker: gray along idle->first->gap->second
	typedef enum logic [1:0] {
		ACK_IDLE  = 2'h0,
		ACK_P1    = 2'h1,
		ACK_GAP   = 2'h3,
		ACK_P2    = 2'h2
	} ack_state_t;
endpackage : host_port_pkg

//--- rtl/host_port_if.sv
// Purpose: pin-level carrier between the host end and the device port
// Assumes: both ends on ref_clk; data bus resolved here from output enables
// Notes: device drives the bus on slave reads and on master writes
`timescale 1ns/1ps
`default_nettype none
interface host_port_if;
	import host_port_pkg::*;
	logic [BUS_W-1:0] host_d;       // host drive value
	logic             host_d_oe;
	logic [BUS_W-1:0] dev_d;        // device drive value
	logic             dev_d_oe;
	logic [BUS_W-1:0] bus_d;        // resolved bus level
	logic             chip_en_b;
	logic             data_strobe_b;
	logic             rd_wr;        // 1 read, 0 write with data strobe
	logic             rd_strobe_b;
	logic             wr_strobe_b;
	logic             section_select;
	logic             interrupt_acknowledge_in_b;
	logic             int_req_b;
	logic             dma_master;   // device owns the bus
	logic             dma_rd_strobe_b;
	logic             dma_wr_strobe_b;
	logic             dma_a0;

	assign bus_d = dev_d_oe ? dev_d : (host_d_oe ? host_d : '0);

	modport device (
		input  bus_d, chip_en_b, data_strobe_b, rd_wr, rd_strobe_b, wr_strobe_b,
		input  section_select, interrupt_acknowledge_in_b,
		output dev_d, dev_d_oe, int_req_b, dma_master, dma_rd_strobe_b, dma_wr_strobe_b, dma_a0
	);
	modport host (
		input  bus_d, int_req_b, dma_master, dma_rd_strobe_b, dma_wr_strobe_b, dma_a0,
		output host_d, host_d_oe, chip_en_b, data_strobe_b, rd_wr, rd_strobe_b, wr_strobe_b,
		output section_select, interrupt_acknowledge_in_b
	);
endinterface : host_port_if
`default_nettype wire

//--- rtl/host_byte_lane_port.sv
// Purpose: device end of the byte-lane host port: decode, lane steering, interrupt chain
// Assumes: pins pass two flops; user side on ref_clk; non-multiplexed bus mode
// Notes: configuration byte is the first write after reset with section_select low
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - all transfers are single bytes
// - slave read byte duplicated on both halves
// - slave writes latch low lane only
// - master write byte copied onto both halves
// - unswapped fetch takes low lane only
// - swapping only for enabled DMA fetches
// - select one: even low, odd high
// - select zero: even high, odd low
// - accept data strobe or read/write strobes
// - strobes count only with chip enable
// - one prioritised interrupt request output
// - each source individually enabled
// - acknowledge input marks acknowledge cycle
// - acknowledge style status, single or double
// - chain resolves lowest-numbered pending at acknowledge
// - low three bits select registers 0-7
// - pointer high selects registers 8-15
// - top two bits give CRC reset
// - pointer clears after second access
// - cfg bits two/one pick acknowledge style
// - cfg bit seven enable, six select
module host_byte_lane_port
	import host_port_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	host_port_if.device            port,
	input  wire logic [NUM_SRC-1:0] int_source,
	input  wire logic [NUM_SRC-1:0] int_enable,
	input  wire logic [BYTE_W-1:0] read_data,
	input  wire logic              dma_req,
	input  wire logic              dma_is_write,
	input  wire logic              dma_addr_a0,
	input  wire logic [BYTE_W-1:0] dma_wr_byte,
	output logic [3:0]             reg_select_reg,
	output logic                   access_rd_reg,
	output logic                   access_wr_reg,
	output logic [BYTE_W-1:0]      write_byte_reg,
	output logic [2:0]             command_reg,
	output logic [1:0]             crc_cmd_reg,
	output logic                   command_pulse_reg,
	output logic [BYTE_W-1:0]      config_reg,
	output logic                   config_valid_reg,
	output logic                   ack_cycle_reg,
	output logic [NUM_SRC-1:0]     ack_grant_reg,
	output logic                   ack_reserved_reg,
	output logic [BYTE_W-1:0]      dma_rd_byte_reg,
	output logic                   dma_done_reg
);
	// pin synchronisers, stage one read only by stage two
	logic [6:0] pin_s1_reg, pin_s2_reg;
	logic [BUS_W-1:0] d_s1_reg, d_s2_reg;
	always_ff @(posedge ref_clk) begin
		pin_s1_reg <= {port.chip_en_b, port.data_strobe_b, port.rd_wr, port.rd_strobe_b,
		               port.wr_strobe_b, port.section_select, port.interrupt_acknowledge_in_b};
		pin_s2_reg <= pin_s1_reg;
		d_s1_reg   <= port.bus_d;
		d_s2_reg   <= d_s1_reg;
	end

	wire ce      = ~pin_s2_reg[6];
	wire ds      = ~pin_s2_reg[5];
	wire rw      =  pin_s2_reg[4];
	wire rd_s    = ~pin_s2_reg[3];
	wire wr_s    = ~pin_s2_reg[2];
	wire sect    =  pin_s2_reg[1];
	wire ack_in  = ~pin_s2_reg[0];

	wire rd_any  = (ds & rw) | rd_s;
	wire wr_any  = (ds & ~rw) | wr_s;
	wire rd_act  = ce & rd_any & ~ack_in;
	wire wr_act  = ce & wr_any & ~ack_in;
	logic rd_prev_reg, wr_prev_reg;
	wire rd_start = rd_act & ~rd_prev_reg;
	wire wr_start = wr_act & ~wr_prev_reg;
	wire [BYTE_W-1:0] wr_byte = d_s2_reg[BYTE_W-1:0];
	wire is_cmd_wr  = wr_start & config_valid_reg & sect & (reg_select_reg == PTR_RESET);
	wire is_cfg_wr  = wr_start & ~config_valid_reg & ~sect;
	wire is_data_acc = (rd_start | wr_start) & config_valid_reg & ~is_cmd_wr;
	wire [2:0] cmd_field = wr_byte[CMD_CODE_HI:CMD_CODE_LO];
	wire [3:0] ptr_next  = {(cmd_field == CMD_POINT_HI), wr_byte[CMD_PTR_HI:CMD_PTR_LO]};

	// register pointer and command capture
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			reg_select_reg    <= PTR_RESET;
			command_reg       <= CMD_NULL;
			crc_cmd_reg       <= CRC_NULL;
			command_pulse_reg <= 1'b0;
			write_byte_reg    <= 8'h00;
			access_rd_reg     <= 1'b0;
			access_wr_reg     <= 1'b0;
			config_reg        <= CFG_RESET;
			config_valid_reg  <= 1'b0;
			rd_prev_reg       <= 1'b0;
			wr_prev_reg       <= 1'b0;
		end else begin
			rd_prev_reg       <= rd_act;
			wr_prev_reg       <= wr_act;
			command_pulse_reg <= is_cmd_wr;
			access_rd_reg     <= rd_start & is_data_acc;
			access_wr_reg     <= wr_start & is_data_acc;
			if (wr_start)
				write_byte_reg <= wr_byte;
			if (is_cfg_wr) begin
				config_reg       <= wr_byte;
				config_valid_reg <= 1'b1;
			end
			if (is_cmd_wr) begin
				command_reg    <= cmd_field;
				crc_cmd_reg    <= wr_byte[CMD_CRC_HI:CMD_CRC_LO];
				reg_select_reg <= ptr_next;
			end else if (access_rd_reg | access_wr_reg) begin
				// pointer clears once the access pulse has shown it
				reg_select_reg <= PTR_RESET;
			end
		end
	end

	wire [1:0] ack_style = {config_reg[CFG_ACK_HI_BIT], config_reg[CFG_ACK_LO_BIT]};
	wire [NUM_SRC-1:0] pend = int_source & int_enable;
	wire [NUM_SRC-1:0] top_pend = pend & ~(pend - NUM_SRC'(1));
	logic ack_prev_reg;
	ack_state_t ack_state_reg, ack_state_next;
	wire ack_rise = ack_in & ~ack_prev_reg;
	wire ack_fall = ~ack_in & ack_prev_reg;

	always_comb begin
		ack_state_next = ack_state_reg;
		case (ack_state_reg)
			ACK_IDLE: begin
				if (ack_rise)
					ack_state_next = ACK_P1;
			end
			ACK_P1: begin
				if (ack_fall)
					ack_state_next = (ack_style == ACK_DOUBLE) ? ACK_GAP : ACK_IDLE;
			end
			ACK_GAP: begin
				if (ack_rise)
					ack_state_next = ACK_P2;
			end
			ACK_P2: begin
				if (ack_fall)
					ack_state_next = ACK_IDLE;
			end
			default: ack_state_next = ACK_IDLE;
		endcase
	end
	// grant taken on the pulse that carries the vector
	wire grant_edge = (ack_style == ACK_DOUBLE) ? (ack_state_reg == ACK_GAP && ack_rise)
	                                            : (ack_state_reg == ACK_IDLE && ack_rise);

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ack_state_reg    <= ACK_IDLE;
			ack_prev_reg     <= 1'b0;
			ack_cycle_reg    <= 1'b0;
			ack_grant_reg    <= '0;
			ack_reserved_reg <= 1'b0;
			port.int_req_b   <= 1'b1;
		end else begin
			ack_state_reg    <= ack_state_next;
			ack_prev_reg     <= ack_in;
			ack_cycle_reg    <= ack_in;
			ack_reserved_reg <= (ack_style == ACK_RSVD);
			port.int_req_b   <= ~(|pend);
			if (grant_edge)
				ack_grant_reg <= top_pend;
			else if (ack_state_next == ACK_IDLE && ack_state_reg != ACK_IDLE)
				ack_grant_reg <= '0;
		end
	end

	wire swap_en  = config_reg[CFG_SWAP_EN_BIT];
	wire swap_sel = config_reg[CFG_SWAP_SEL_BIT];
	wire use_high = swap_en & (swap_sel ? dma_addr_a0 : ~dma_addr_a0);
	wire [BYTE_W-1:0] fetch_byte = use_high ? d_s2_reg[BUS_W-1:BYTE_W] : d_s2_reg[BYTE_W-1:0];
	wire slave_drive = rd_act & config_valid_reg;
	logic [1:0] dma_step_reg;

	// bus drive and one-byte master transfers
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			port.dev_d           <= '0;
			port.dev_d_oe        <= 1'b0;
			port.dma_master      <= 1'b0;
			port.dma_rd_strobe_b <= 1'b1;
			port.dma_wr_strobe_b <= 1'b1;
			port.dma_a0          <= 1'b0;
			dma_rd_byte_reg      <= 8'h00;
			dma_done_reg         <= 1'b0;
			dma_step_reg         <= 2'h0;
		end else begin
			dma_done_reg <= 1'b0;
			if (port.dma_master) begin
				dma_step_reg <= dma_step_reg + 2'h1;
				if (dma_step_reg == DMA_LAST_STEP) begin
					port.dma_master      <= 1'b0;
					port.dma_rd_strobe_b <= 1'b1;
					port.dma_wr_strobe_b <= 1'b1;
					port.dev_d_oe        <= 1'b0;
					dma_done_reg         <= 1'b1;
					if (port.dma_wr_strobe_b)
						dma_rd_byte_reg <= fetch_byte;
				end
			end else if (dma_req & ~ce) begin
				port.dma_master      <= 1'b1;
				port.dma_a0          <= dma_addr_a0;
				dma_step_reg         <= 2'h0;
				port.dma_wr_strobe_b <= ~dma_is_write;
				port.dma_rd_strobe_b <= dma_is_write;
				// master write copied to both lanes
				port.dev_d           <= {dma_wr_byte, dma_wr_byte};
				port.dev_d_oe        <= dma_is_write;
			end else begin
				// slave read duplicated on both lanes
				port.dev_d    <= {read_data, read_data};
				port.dev_d_oe <= slave_drive;
			end
		end
	end
endmodule : host_byte_lane_port
`default_nettype wire

//--- rtl/host_bus_master.sv
// Purpose: host end: runs byte reads, writes and acknowledge pulses on the port
// Assumes: user commands on ref_clk; device answers sampled through two flops
// Notes: each access holds strobes for a fixed number of cycles
`timescale 1ns/1ps
`default_nettype none
module host_bus_master
	import host_port_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	host_port_if.host              port,
	input  wire logic              req_valid,
	input  wire logic              req_write,
	input  wire logic              req_split,
	input  wire logic              req_ack,
	input  wire logic              req_double,
	input  wire logic              req_sect,
	input  wire logic [BYTE_W-1:0] req_byte,
	output logic                   busy_reg,
	output logic                   done_reg,
	output logic [BYTE_W-1:0]      rd_byte_reg,
	output logic                   irq_reg
);
	logic [BUS_W-1:0] d_s1_reg, d_s2_reg;
	logic             irq_s1_reg;
	logic [3:0]       cnt_reg;
	logic             second_reg;
	always_ff @(posedge ref_clk) begin
		d_s1_reg   <= port.bus_d;
		d_s2_reg   <= d_s1_reg;
		irq_s1_reg <= ~port.int_req_b;
		irq_reg    <= irq_s1_reg;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			busy_reg    <= 1'b0;
			done_reg    <= 1'b0;
			rd_byte_reg <= 8'h00;
			cnt_reg     <= 4'h0;
			second_reg  <= 1'b0;
			port.host_d <= '0;
			port.host_d_oe <= 1'b0;
			port.chip_en_b <= 1'b1;
			port.data_strobe_b <= 1'b1;
			port.rd_wr <= 1'b1;
			port.rd_strobe_b <= 1'b1;
			port.wr_strobe_b <= 1'b1;
			port.section_select <= 1'b0;
			port.interrupt_acknowledge_in_b <= 1'b1;
		end else begin
			done_reg <= 1'b0;
			if (!busy_reg) begin
				if (req_valid & ~port.dma_master) begin
					busy_reg   <= 1'b1;
					cnt_reg    <= 4'h0;
					second_reg <= req_double;
					port.section_select <= req_sect;
					if (req_ack) begin
						port.interrupt_acknowledge_in_b <= 1'b0;
					end else begin
						port.chip_en_b <= 1'b0;
						port.host_d    <= {8'h00, req_byte};
						port.host_d_oe <= req_write;
						if (req_split) begin
							port.rd_strobe_b <= req_write;
							port.wr_strobe_b <= ~req_write;
						end else begin
							port.data_strobe_b <= 1'b0;
							port.rd_wr         <= ~req_write;
						end
					end
				end else begin
					// memory side: answer a master fetch, low lane the byte, high lane its inverse
					port.host_d    <= {~req_byte, req_byte};
					port.host_d_oe <= ~port.dma_rd_strobe_b;
				end
			end else begin
				cnt_reg <= cnt_reg + 4'h1;
				if (cnt_reg == HOLD_CYCLES) begin
					rd_byte_reg <= d_s2_reg[BYTE_W-1:0];
					port.chip_en_b <= 1'b1;
					port.data_strobe_b <= 1'b1;
					port.rd_strobe_b <= 1'b1;
					port.wr_strobe_b <= 1'b1;
					port.rd_wr <= 1'b1;
					port.host_d_oe <= 1'b0;
					port.interrupt_acknowledge_in_b <= 1'b1;
				end else if (cnt_reg == HOLD_CYCLES + RELEASE_GAP) begin
					if (second_reg) begin
						second_reg <= 1'b0;
						cnt_reg    <= 4'h0;
						port.interrupt_acknowledge_in_b <= 1'b0;
					end else begin
						busy_reg <= 1'b0;
						done_reg <= 1'b1;
					end
				end
			end
		end
	end
endmodule : host_bus_master
`default_nettype wire

//--- verif/host_port_properties.sv
// Purpose: wire-level properties of the byte-lane host port
// Assumes: one clock, synchronous active-low reset
// Notes: instantiated beside the carrier interface, fed its signals
`timescale 1ns/1ps
`default_nettype none
module host_port_properties
	import host_port_pkg::*;
(
	input wire logic             ref_clk,
	input wire logic             rst_b,
	input wire logic [BUS_W-1:0] dev_d,
	input wire logic             dev_d_oe,
	input wire logic             chip_en_b,
	input wire logic             data_strobe_b,
	input wire logic             rd_wr,
	input wire logic             wr_strobe_b,
	input wire logic             interrupt_acknowledge_in_b,
	input wire logic             dma_master,
	input wire logic             dma_rd_strobe_b,
	input wire logic             dma_wr_strobe_b
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// slave write in either strobe style, host idle, one bus tenure
	sequence s_slave_wr;
		!chip_en_b && !dma_master && ((!data_strobe_b && !rd_wr) || !wr_strobe_b);
	endsequence
	sequence s_quiet;
		chip_en_b && !dma_master && interrupt_acknowledge_in_b;
	endsequence
	sequence s_tenure;
		dma_master [*4] ##1 !dma_master;
	endsequence
	// properties on the device drive and the master strobes
	property p_dup_lanes; dev_d_oe |-> dev_d[BUS_W-1:BYTE_W] == dev_d[BYTE_W-1:0]; endproperty
	a_dup_lanes: assert property (p_dup_lanes) else $error("device lanes differ");
	property p_rd_ce; $rose(dev_d_oe) && !dma_master |-> !$past(chip_en_b, 2); endproperty
	a_rd_ce: assert property (p_rd_ce) else $error("drive without chip enable");
	property p_wr_quiet; s_slave_wr [*5] |-> !dev_d_oe; endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("drive during slave write");
	property p_idle; s_quiet [*5] |-> !dev_d_oe; endproperty
	a_idle: assert property (p_idle) else $error("drive while deselected");
	property p_tenure; $rose(dma_master) |-> s_tenure; endproperty
	a_tenure: assert property (p_tenure) else $error("bus tenure length wrong");
	property p_fetch; !dma_rd_strobe_b |-> !dev_d_oe; endproperty
	a_fetch: assert property (p_fetch) else $error("drive during fetch");
	property p_store; !dma_wr_strobe_b |-> dev_d_oe && dma_master; endproperty
	a_store: assert property (p_store) else $error("store without drive");
	property p_owner; !dma_master |-> dma_rd_strobe_b && dma_wr_strobe_b; endproperty
	a_owner: assert property (p_owner) else $error("master strobe without bus");
endmodule : host_port_properties
`default_nettype wire

//--- verif/host_bus_byte_lane_port_tb_top.sv
// Purpose: self-checking bench joining the host end and the device port
// Assumes: 50 MHz ref_clk, inputs driven on the falling edge
// Notes: drivers note expectations in queues, one monitor drains them
`timescale 1ns/1ps
`default_nettype none
module host_bus_byte_lane_port_tb_top;
	import host_port_pkg::*;
	localparam logic [7:0] CFGS [4] = '{8'h00, 8'hC2, 8'h86, 8'h44};
	logic                ref_clk, rst_b, dma_req, dma_is_write, dma_addr_a0;
	logic [NUM_SRC-1:0]  int_source, int_enable, ack_grant_reg, grant_prev, p;
	logic [BYTE_W-1:0]   read_data, dma_wr_byte, req_byte, write_byte_reg, config_reg, dma_rd_byte_reg, rd_byte_reg;
	logic                req_valid, req_write, req_split, req_ack, req_double, req_sect;
	logic [3:0]          reg_select_reg;
	logic                access_rd_reg, access_wr_reg, command_pulse_reg, config_valid_reg, ack_cycle_reg;
	logic [2:0]          command_reg;
	logic [1:0]          crc_cmd_reg;
	logic                ack_reserved_reg, dma_done_reg, busy_reg, done_reg, irq_reg;
	logic [15:0]         cap_bus, e, q_cmd[$], q_acc[$], q_rd[$], q_dma[$], q_ack[$];
	logic [7:0]          cfg;
	logic [31:0]         r;
	int                  n_fail, n_tests, i;
	integer              seed;

	host_port_if hp_if ();
	host_byte_lane_port host_byte_lane_port_inst (.ref_clk, .rst_b, .port(hp_if), .int_source, .int_enable,
		.read_data, .dma_req, .dma_is_write, .dma_addr_a0, .dma_wr_byte, .reg_select_reg, .access_rd_reg,
		.access_wr_reg, .write_byte_reg, .command_reg, .crc_cmd_reg, .command_pulse_reg, .config_reg,
		.config_valid_reg, .ack_cycle_reg, .ack_grant_reg, .ack_reserved_reg, .dma_rd_byte_reg, .dma_done_reg);
	host_bus_master host_bus_master_inst (.ref_clk, .rst_b, .port(hp_if), .req_valid, .req_write, .req_split,
		.req_ack, .req_double, .req_sect, .req_byte, .busy_reg, .done_reg, .rd_byte_reg, .irq_reg);
	host_port_properties host_port_properties_inst (.ref_clk, .rst_b, .dev_d(hp_if.dev_d),
		.dev_d_oe(hp_if.dev_d_oe), .chip_en_b(hp_if.chip_en_b), .data_strobe_b(hp_if.data_strobe_b),
		.rd_wr(hp_if.rd_wr), .wr_strobe_b(hp_if.wr_strobe_b), .dma_master(hp_if.dma_master),
		.interrupt_acknowledge_in_b(hp_if.interrupt_acknowledge_in_b),
		.dma_rd_strobe_b(hp_if.dma_rd_strobe_b), .dma_wr_strobe_b(hp_if.dma_wr_strobe_b));

	// free-running clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict

	task automatic stuck(input string name);
		n_fail++;
		$display("[ERR] %s expected done seen none", name);
		give_verdict();
	endtask : stuck

	// one host access: request pulse, then wait for done under a bound
	task automatic host_op(input logic wr, sp, sect, ack, dbl, input logic [7:0] b);
		int k;
		q_rd.push_back({7'h0, !wr && !ack, (!wr && !ack) ? read_data : 8'h00});
		req_write = wr;
		req_split = sp;
		req_sect = sect;
		req_ack = ack;
		req_double = dbl;
		req_byte = b;
		req_valid = 1'b1;
		@(negedge ref_clk);
		req_valid = 1'b0;
		for (k = 0; k < 60 && !done_reg; k++) @(negedge ref_clk);
		if (k == 60) stuck("host access");
		chk("host busy", 16'h0, {15'h0, busy_reg});
		@(negedge ref_clk);
	endtask : host_op

	// one DMA byte: request held until the device takes the bus
	task automatic dma_op(input logic wr, a0, input logic [7:0] b);
		int k;
		q_dma.push_back({6'h0, wr, a0, b});
		dma_is_write = wr;
		dma_addr_a0 = a0;
		dma_wr_byte = b;
		req_byte = b;
		dma_req = 1'b1;
		for (k = 0; k < 40 && !hp_if.dma_master; k++) @(negedge ref_clk);
		dma_req = 1'b0;
		for (k = 0; k < 40 && !dma_done_reg; k++) @(negedge ref_clk);
		if (k == 40) stuck("dma transfer");
		@(negedge ref_clk);
	endtask : dma_op

	// remember the wire while a master strobe is low
	always @(posedge ref_clk) begin
		if (!hp_if.dma_rd_strobe_b || !hp_if.dma_wr_strobe_b) begin
			cap_bus <= hp_if.bus_d;
		end
	end

	// monitor: the oldest note of each kind is taken when its result shows
	always @(posedge ref_clk) begin
		grant_prev <= ack_grant_reg;
		if (rst_b && command_pulse_reg) begin
			e = q_cmd.size() ? q_cmd.pop_front() : 'x;
			chk("command", e, {7'h0, crc_cmd_reg, command_reg, reg_select_reg});
		end
		if (rst_b && (access_rd_reg || access_wr_reg)) begin
			e = q_acc.size() ? q_acc.pop_front() : 'x;
			chk("access", e, {2'h0, access_rd_reg, access_wr_reg, reg_select_reg,
				access_wr_reg ? write_byte_reg : 8'h00});
		end
		if (rst_b && done_reg) begin
			e = q_rd.size() ? q_rd.pop_front() : 'x;
			chk("read byte", e, {7'h0, e[8], e[8] ? rd_byte_reg : 8'h00});
		end
		if (rst_b && dma_done_reg) begin
			e = q_dma.size() ? q_dma.pop_front() : 'x;
			chk("dma byte", e[9] ? {e[7:0], e[7:0]} : {8'h0, (cfg[7] && cfg[6] == e[8]) ? cap_bus[15:8] : cap_bus[7:0]},
				e[9] ? cap_bus : {8'h0, dma_rd_byte_reg});
		end
		if (rst_b && ack_grant_reg != '0 && grant_prev == '0) begin
			e = q_ack.size() ? q_ack.pop_front() : 'x;
			chk("grant", e, {12'h0, ack_grant_reg});
			chk("ack cycle", 16'h1, {15'h0, ack_cycle_reg});
		end
	end

	// main sequence: one reset and configuration per style
	initial begin
		seed = 32'h4CF0;
		n_fail = 0;
		n_tests = 0;
		{rst_b, dma_req, dma_is_write, dma_addr_a0, dma_wr_byte, read_data} = '0;
		{req_valid, req_write, req_split, req_ack, req_double, req_sect, req_byte} = '0;
		{int_source, int_enable, cfg} = '0;
		foreach (CFGS[c]) begin
			cfg = CFGS[c];
			rst_b = 1'b0;
			repeat (6) @(negedge ref_clk);
			rst_b = 1'b1;
			host_op(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, cfg);
			chk("config", {8'h0, cfg}, {8'h0, config_reg});
			chk("reserved style", {15'h0, cfg[2:1] == ACK_RSVD}, {15'h0, ack_reserved_reg});
			chk("config valid", 16'h1, {15'h0, config_valid_reg});
			// every command, then one pointed access
			for (i = 0; i < 8; i++) begin
				r = $random(seed);
				// a pointed write never aims at the command byte itself
				r[0] = r[0] | i[1];
				q_cmd.push_back({7'h0, i[1:0], i[2:0], i == 1, r[2:0]});
				host_op(1'b1, i[0], 1'b1, 1'b0, 1'b0, {i[1:0], i[2:0], r[2:0]});
				read_data = r[15:8];
				q_acc.push_back({2'h0, !i[1], i[1], i == 1, r[2:0], i[1] ? r[23:16] : 8'h00});
				host_op(i[1], !i[0], 1'b1, 1'b0, 1'b0, r[23:16]);
			end
			for (i = 0; i < 4; i++) begin
				r = $random(seed);
				dma_op(i[1], i[0], r[7:0]);
			end
			r = $random(seed);
			int_enable = '0;
			int_source = r[3:0] | 4'h8;
			repeat (8) @(negedge ref_clk);
			chk("masked request", 16'h1, {15'h0, hp_if.int_req_b});
			chk("host irq", 16'h0, {15'h0, irq_reg});
			int_enable = r[7:4] | 4'h8;
			repeat (8) @(negedge ref_clk);
			chk("request", 16'h0, {15'h0, hp_if.int_req_b});
			chk("host irq", 16'h1, {15'h0, irq_reg});
			p = int_source & int_enable;
			q_ack.push_back({12'h0, p & (~p + 4'h1)});
			host_op(1'b0, 1'b0, 1'b1, 1'b1, cfg[2:1] == ACK_DOUBLE, 8'h00);
		end
		repeat (4) @(negedge ref_clk);
		chk("open notes", 16'h0, 16'(q_cmd.size() + q_acc.size() + q_rd.size() + q_dma.size() + q_ack.size()));
		give_verdict();
	end
endmodule : host_bus_byte_lane_port_tb_top
`default_nettype wire
